// File: rtl/ilcl_pkg.sv
// Constants, register map and types of the input level control loop
package ilcl_pkg;

    // Register indices of the control port
    localparam logic [6:0] ADDR_CTRL_ONE   = 7'h20;
    localparam logic [6:0] ADDR_CTRL_TWO   = 7'h21;
    localparam logic [6:0] ADDR_CTRL_THREE = 7'h22;
    localparam logic [6:0] ADDR_QUIET_GATE = 7'h23;

    // Field positions
    localparam int ENABLE_BIT      = 8;
    localparam int CEIL_LSB        = 3;
    localparam int FLOOR_LSB       = 0;
    localparam int ZC_BIT          = 8;
    localparam int HOLD_LSB        = 4;
    localparam int TARGET_LSB      = 0;
    localparam int MODE_BIT        = 8;
    localparam int RISE_LSB        = 4;
    localparam int FALL_LSB        = 0;
    localparam int GATE_EN_BIT     = 3;
    localparam int QUIET_LSB       = 0;

    // Reset values
    localparam logic [8:0] CTRL_ONE_RESET   = 9'h038;
    localparam logic [8:0] CTRL_TWO_RESET   = 9'h00b;
    localparam logic [8:0] CTRL_THREE_RESET = 9'h032;
    localparam logic [3:0] QUIET_GATE_RESET = 4'h0;
    localparam logic [5:0] GAIN_RESET       = 6'h10;

    // Step and hold times per code 0000 (hold: code 0001)
    localparam int SAMPLE_PERIOD_NS = 20833;
    localparam int FALL_NORM_NS     = 104000;
    localparam int RISE_NORM_NS     = 410000;
    localparam int FALL_LIM_NS      = 22700;
    localparam int RISE_LIM_NS      = 90800;
    localparam int HOLD_NS          = 2670000;
    localparam int FALL_NORM_SAMPLES = (FALL_NORM_NS + SAMPLE_PERIOD_NS / 2) / SAMPLE_PERIOD_NS;
    localparam int RISE_NORM_SAMPLES = (RISE_NORM_NS + SAMPLE_PERIOD_NS / 2) / SAMPLE_PERIOD_NS;
    localparam int FALL_LIM_SAMPLES  = (FALL_LIM_NS + SAMPLE_PERIOD_NS / 2) / SAMPLE_PERIOD_NS;
    localparam int RISE_LIM_SAMPLES  = (RISE_LIM_NS + SAMPLE_PERIOD_NS / 2) / SAMPLE_PERIOD_NS;
    localparam int HOLD_SAMPLES      = (HOLD_NS + SAMPLE_PERIOD_NS / 2) / SAMPLE_PERIOD_NS;
    localparam logic [3:0] RATE_CODE_MAX = 4'ha;

    // Widths
    localparam int SAMPLE_W_DEF = 16;
    localparam int CNT_W_DEF    = 20;
    localparam int GAIN_W       = 6;

    // Peak levels at 16-bit magnitude, full scale 32768
    localparam logic [15:0] CLAMP_LEVEL = 16'h7000;
    localparam logic [15:0] TARGET_LEVEL [16] = '{
        16'h04d0, 16'h05b8, 16'h06cc, 16'h0814, 16'h0999, 16'h0b68, 16'h0d8e, 16'h101d,
        16'h1326, 16'h16c3, 16'h1b0d, 16'h2027, 16'h2636, 16'h2d6b, 16'h35fa, 16'h4027
    };

    // Gate level: mantissa of 2^(j/8) at -51 dBFS, scaled by 256
    localparam logic [7:0] GATE_MANT [8] = '{
        8'h5c, 8'h65, 8'h6e, 8'h78, 8'h83, 8'h8e, 8'h9b, 8'ha9
    };
    localparam logic [6:0] GATE_BIAS = 7'h40;

    typedef enum logic [1:0] {
        LOOP_OFF,
        LOOP_NORMAL,
        LOOP_LIMIT
    } ilcl_state_t;

endpackage : ilcl_pkg

// File: rtl/ilcl_tick_counter.sv
// Loadable down counter stepped by sample ticks
`timescale 1ns/1ps
`default_nettype none
module ilcl_tick_counter #(
    parameter int CNT_W = 20
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             ce,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] loadValue,
    input  wire logic             tick,
    output logic                  zero
);

    logic [CNT_W-1:0] count;

    generate
        if (CNT_W < 2) begin : g_bad_width
            $error("ilcl_tick_counter: CNT_W too small");
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else if (ce) begin
            if (load) begin
                count <= loadValue;
            end else if (tick && (count != '0)) begin
                count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign zero = (count == '0);

endmodule : ilcl_tick_counter
`default_nettype wire

// File: rtl/ilcl_level_loop.sv
// Automatic level control loop for the record path amplifier
`timescale 1ns/1ps
`default_nettype none
module ilcl_level_loop #(
    parameter int SAMPLE_W       = ilcl_pkg::SAMPLE_W_DEF,
    parameter int CNT_W          = ilcl_pkg::CNT_W_DEF,
    parameter int FALL_NORM_BASE = ilcl_pkg::FALL_NORM_SAMPLES,
    parameter int RISE_NORM_BASE = ilcl_pkg::RISE_NORM_SAMPLES,
    parameter int FALL_LIM_BASE  = ilcl_pkg::FALL_LIM_SAMPLES,
    parameter int RISE_LIM_BASE  = ilcl_pkg::RISE_LIM_SAMPLES,
    parameter int HOLD_BASE      = ilcl_pkg::HOLD_SAMPLES
) (
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    input  wire logic                       ce,
    input  wire logic                       regWrEn,
    input  wire logic [6:0]                 regAddr,
    input  wire logic [8:0]                 regWrData,
    output logic      [8:0]                 regRdData,
    input  wire logic                       sampleStrobe,
    input  wire logic [SAMPLE_W-1:0]        adcSample,
    input  wire logic [2:0]                 sampleRateCode,
    input  wire logic                       gainWrEn,
    input  wire logic [ilcl_pkg::GAIN_W-1:0] gainWrData,
    output logic      [ilcl_pkg::GAIN_W-1:0] pgaGain,
    output logic                            loopActive
);

    localparam int GW = ilcl_pkg::GAIN_W;

    generate
        if (SAMPLE_W < 16 || CNT_W < 18) begin : g_bad_width
            $error("ilcl_level_loop: SAMPLE_W must be >= 16 and CNT_W >= 18");
        end
        if (FALL_NORM_BASE < 1 || RISE_NORM_BASE < 1 || FALL_LIM_BASE < 1 ||
            RISE_LIM_BASE < 1 || HOLD_BASE < 1) begin : g_bad_base
            $error("ilcl_level_loop: base counts must be at least 1");
        end
        if ((HOLD_BASE << 9) >= (1 << CNT_W) || (RISE_NORM_BASE << 10) >= (1 << CNT_W))
        begin : g_bad_range
            $error("ilcl_level_loop: CNT_W too small for the base counts");
        end
    endgenerate

    // Control registers
    logic [8:0] ctrlOne;
    logic [8:0] ctrlTwo;
    logic [8:0] ctrlThree;
    logic [3:0] quietGateCtrl;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrlOne       <= ilcl_pkg::CTRL_ONE_RESET;
            ctrlTwo       <= ilcl_pkg::CTRL_TWO_RESET;
            ctrlThree     <= ilcl_pkg::CTRL_THREE_RESET;
            quietGateCtrl <= ilcl_pkg::QUIET_GATE_RESET;
        end else if (ce && regWrEn) begin
            case (regAddr)
                ilcl_pkg::ADDR_CTRL_ONE:   ctrlOne       <= regWrData;
                ilcl_pkg::ADDR_CTRL_TWO:   ctrlTwo       <= regWrData;
                ilcl_pkg::ADDR_CTRL_THREE: ctrlThree     <= regWrData;
                ilcl_pkg::ADDR_QUIET_GATE: quietGateCtrl <= regWrData[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= '0;
        end else if (ce) begin
            case (regAddr)
                ilcl_pkg::ADDR_CTRL_ONE:   regRdData <= ctrlOne;
                ilcl_pkg::ADDR_CTRL_TWO:   regRdData <= ctrlTwo;
                ilcl_pkg::ADDR_CTRL_THREE: regRdData <= ctrlThree;
                ilcl_pkg::ADDR_QUIET_GATE: regRdData <= {5'h00, quietGateCtrl};
                default:                   regRdData <= '0;
            endcase
        end
    end

    // Field views
    logic       levelLoopEnable;
    logic [2:0] gainCeiling;
    logic [2:0] gainFloor;
    logic       zeroCrossGate;
    logic [3:0] holdTimeCode;
    logic [3:0] levelTarget;
    logic       loopModeSelect;
    logic [3:0] gainRiseRate;
    logic [3:0] gainFallRate;
    logic       quietGateEnable;
    logic [2:0] quietThreshold;

    assign levelLoopEnable = ctrlOne[ilcl_pkg::ENABLE_BIT];
    assign gainCeiling     = ctrlOne[ilcl_pkg::CEIL_LSB +: 3];
    assign gainFloor       = ctrlOne[ilcl_pkg::FLOOR_LSB +: 3];
    assign zeroCrossGate   = ctrlTwo[ilcl_pkg::ZC_BIT];
    assign holdTimeCode    = ctrlTwo[ilcl_pkg::HOLD_LSB +: 4];
    assign levelTarget     = ctrlTwo[ilcl_pkg::TARGET_LSB +: 4];
    assign loopModeSelect  = ctrlThree[ilcl_pkg::MODE_BIT];
    assign gainRiseRate    = ctrlThree[ilcl_pkg::RISE_LSB +: 4];
    assign gainFallRate    = ctrlThree[ilcl_pkg::FALL_LSB +: 4];
    assign quietGateEnable = quietGateCtrl[ilcl_pkg::GATE_EN_BIT];
    assign quietThreshold  = quietGateCtrl[ilcl_pkg::QUIET_LSB +: 3];

    // Loop state
    ilcl_pkg::ilcl_state_t loopState;
    ilcl_pkg::ilcl_state_t next_loopState;

    always_comb begin
        case ({levelLoopEnable, loopModeSelect})
            2'b10:   next_loopState = ilcl_pkg::LOOP_NORMAL;
            2'b11:   next_loopState = ilcl_pkg::LOOP_LIMIT;
            default: next_loopState = ilcl_pkg::LOOP_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loopState <= ilcl_pkg::LOOP_OFF;
        end else if (ce) begin
            loopState <= next_loopState;
        end
    end

    logic loopOn;
    logic limiterOn;
    logic normalOn;

    assign loopOn     = (loopState != ilcl_pkg::LOOP_OFF);
    assign limiterOn  = (loopState == ilcl_pkg::LOOP_LIMIT);
    assign normalOn   = (loopState == ilcl_pkg::LOOP_NORMAL);
    assign loopActive = loopOn;

    // Sample magnitude and peak window
    logic [SAMPLE_W-1:0] sampleMag;
    logic [15:0]         mag16;
    logic [15:0]         peakMax;
    logic [15:0]         curPeak;
    logic                prevSign;
    logic                zcEvent;

    assign sampleMag = adcSample[SAMPLE_W-1] ?
                       (~adcSample) + {{(SAMPLE_W-1){1'b0}}, 1'b1} : adcSample;
    assign mag16     = sampleMag[SAMPLE_W-1 -: 16];
    assign curPeak   = (mag16 > peakMax) ? mag16 : peakMax;
    assign zcEvent   = sampleStrobe && (adcSample[SAMPLE_W-1] != prevSign);

    logic stepFire;
    logic stepZero;
    logic holdZero;

    assign stepFire = sampleStrobe && stepZero && loopOn;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            peakMax <= '0;
        end else if (ce) begin
            if (!loopOn) begin
                peakMax <= '0;
            end else if (stepFire) begin
                peakMax <= '0;
            end else if (sampleStrobe) begin
                peakMax <= curPeak;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prevSign <= 1'b0;
        end else if (ce && sampleStrobe) begin
            prevSign <= adcSample[SAMPLE_W-1];
        end
    end

    // Level comparisons
    logic [15:0] targetLevel;
    logic [6:0]  gateIndex;
    logic [23:0] gateWide;
    logic [15:0] gateLevel;
    logic        clampSeen;
    logic        windowAbove;
    logic        sampleAbove;
    logic        gateOn;

    assign targetLevel = ilcl_pkg::TARGET_LEVEL[levelTarget];
    // Pin level below threshold: ADC level below threshold plus amplifier gain
    assign gateIndex   = {1'b0, pgaGain} + ilcl_pkg::GATE_BIAS - {1'b0, quietThreshold, 3'b000};
    assign gateWide    = {16'h0000, ilcl_pkg::GATE_MANT[gateIndex[2:0]]} << gateIndex[6:3];
    assign gateLevel   = gateWide[23:8];
    assign clampSeen   = (curPeak > ilcl_pkg::CLAMP_LEVEL);
    assign windowAbove = (curPeak > targetLevel);
    assign sampleAbove = (mag16 > targetLevel);
    assign gateOn      = quietGateEnable && normalOn && (curPeak < gateLevel);

    // Period scaling by code and sample rate
    logic [1:0] rateShift;

    always_comb begin
        case (sampleRateCode[2:1])
            2'b00:   rateShift = 2'd0;
            2'b01:   rateShift = 2'd1;
            default: rateShift = 2'd2;
        endcase
    end

    function automatic logic [CNT_W-1:0] scaledCount(input logic [CNT_W-1:0] base,
                                                     input logic [3:0]       code,
                                                     input logic [1:0]       sh);
        logic [3:0]       c;
        logic [CNT_W-1:0] v;
        c = (code > ilcl_pkg::RATE_CODE_MAX) ? ilcl_pkg::RATE_CODE_MAX : code;
        v = (base << c) >> sh;
        if (v == '0) begin
            v = {{(CNT_W-1){1'b0}}, 1'b1};
        end
        scaledCount = v;
    endfunction : scaledCount

    logic [CNT_W-1:0] fallBase;
    logic [CNT_W-1:0] riseBase;
    logic [CNT_W-1:0] stepPeriod;
    logic [CNT_W-1:0] holdPeriod;
    logic [3:0]       holdCodeClip;

    assign fallBase = limiterOn ? CNT_W'(FALL_LIM_BASE) : CNT_W'(FALL_NORM_BASE);
    assign riseBase = limiterOn ? CNT_W'(RISE_LIM_BASE) : CNT_W'(RISE_NORM_BASE);

    always_comb begin
        if (clampSeen) begin
            stepPeriod = scaledCount(CNT_W'(FALL_NORM_BASE), 4'h0, rateShift);
        end else if (windowAbove) begin
            stepPeriod = scaledCount(fallBase, gainFallRate, rateShift);
        end else begin
            stepPeriod = scaledCount(riseBase, gainRiseRate, rateShift);
        end
    end

    assign holdCodeClip = (holdTimeCode > ilcl_pkg::RATE_CODE_MAX) ?
                          ilcl_pkg::RATE_CODE_MAX : holdTimeCode;
    assign holdPeriod   = (holdTimeCode == 4'h0) ? '0 :
                          scaledCount(CNT_W'(HOLD_BASE), holdCodeClip - 4'h1, rateShift);

    // Step and hold timers
    ilcl_tick_counter #(
        .CNT_W     (CNT_W)
    ) u_step_timer (
        .clk       (clk),
        .arst_n    (arst_n),
        .ce        (ce),
        .load      (!loopOn || stepFire),
        .loadValue (loopOn ? stepPeriod - {{(CNT_W-1){1'b0}}, 1'b1} : '0),
        .tick      (sampleStrobe),
        .zero      (stepZero)
    );

    ilcl_tick_counter #(
        .CNT_W     (CNT_W)
    ) u_hold_timer (
        .clk       (clk),
        .arst_n    (arst_n),
        .ce        (ce),
        .load      (!normalOn || (sampleStrobe && sampleAbove)),
        .loadValue (holdPeriod),
        .tick      (sampleStrobe),
        .zero      (holdZero)
    );

    // Step decision
    logic [GW-1:0] ceilIdx;
    logic [GW-1:0] floorIdx;
    logic [GW-1:0] startGain;
    logic          wantDown;
    logic          wantUp;
    logic          pendUp;
    logic          pendDown;
    logic          effUp;
    logic          effDown;
    logic          applyNow;
    logic          upRoom;

    assign ceilIdx  = {gainCeiling, 3'b111};
    assign floorIdx = {gainFloor, 3'b000};
    assign wantDown = stepFire && (clampSeen || windowAbove);
    assign wantUp   = stepFire && !clampSeen && !windowAbove &&
                      (limiterOn || (!gateOn && holdZero));
    assign effDown  = wantDown || (!wantUp && pendDown);
    assign effUp    = wantUp || (!wantDown && pendUp);
    assign applyNow = !zeroCrossGate || zcEvent;
    assign upRoom   = (pgaGain < ceilIdx) && (!limiterOn || (pgaGain < startGain));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pendUp   <= 1'b0;
            pendDown <= 1'b0;
        end else if (ce) begin
            if (!loopOn || gainWrEn) begin
                pendUp   <= 1'b0;
                pendDown <= 1'b0;
            end else if (applyNow && (effUp || effDown)) begin
                pendUp   <= 1'b0;
                pendDown <= 1'b0;
            end else if (wantUp || wantDown) begin
                pendUp   <= wantUp;
                pendDown <= wantDown;
            end
        end
    end

    // Limiter start level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            startGain <= ilcl_pkg::GAIN_RESET;
        end else if (ce) begin
            if (next_loopState == ilcl_pkg::LOOP_LIMIT && loopState != ilcl_pkg::LOOP_LIMIT) begin
                startGain <= pgaGain;
            end else if (gainWrEn && limiterOn) begin
                startGain <= gainWrData;
            end
        end
    end

    // Amplifier gain
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pgaGain <= ilcl_pkg::GAIN_RESET;
        end else if (ce) begin
            if (gainWrEn) begin
                pgaGain <= gainWrData;
            end else if (loopOn) begin
                if (pgaGain > ceilIdx) begin
                    pgaGain <= ceilIdx;
                end else if (pgaGain < floorIdx) begin
                    pgaGain <= floorIdx;
                end else if (applyNow && effDown && (pgaGain > floorIdx)) begin
                    pgaGain <= pgaGain - {{(GW-1){1'b0}}, 1'b1};
                end else if (applyNow && effUp && upRoom) begin
                    pgaGain <= pgaGain + {{(GW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule : ilcl_level_loop
`default_nettype wire

// File: tb/ilcl_level_loop_checker.sv
// Port assertions of the input level control loop
`timescale 1ns/1ps
`default_nettype none
module ilcl_level_loop_checker #(
    parameter int SAMPLE_W = 16
) (
    input wire logic                clk,
    input wire logic                arst_n,
    input wire logic                ce,
    input wire logic                regWrEn,
    input wire logic [6:0]          regAddr,
    input wire logic [8:0]          regWrData,
    input wire logic [8:0]          regRdData,
    input wire logic                sampleStrobe,
    input wire logic [SAMPLE_W-1:0] adcSample,
    input wire logic [2:0]          sampleRateCode,
    input wire logic                gainWrEn,
    input wire logic [5:0]          gainWrData,
    input wire logic [5:0]          pgaGain,
    input wire logic                loopActive
);
    logic [5:0] limCodes;
    logic [5:0] ceilIdx;
    logic [5:0] floorIdx;

    // Mirror of ceiling and floor codes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            limCodes <= ilcl_pkg::CTRL_ONE_RESET[5:0];
        end else if (ce && regWrEn && regAddr == ilcl_pkg::ADDR_CTRL_ONE) begin
            limCodes <= regWrData[5:0];
        end
    end
    assign ceilIdx  = {limCodes[5:3], 3'h7};
    assign floorIdx = {limCodes[2:0], 3'h0};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_enWrite;
        ce && regWrEn && regAddr == ilcl_pkg::ADDR_CTRL_ONE && regWrData[8];
    endsequence
    sequence s_offWrite;
        ce && regWrEn && regAddr == ilcl_pkg::ADDR_CTRL_ONE && !regWrData[8];
    endsequence
    sequence s_ctrlWrite;
        ce && regWrEn && regAddr inside {7'h20, 7'h21, 7'h22};
    endsequence
    sequence s_readAfter;
        ce && !regWrEn && $stable(regAddr);
    endsequence

    property p_enable; s_enWrite |-> ##[1:3] loopActive; endproperty
    property p_disable; s_offWrite |-> ##[1:3] !loopActive; endproperty
    property p_offHold; ce && !loopActive && !gainWrEn |=> $stable(pgaGain); endproperty
    property p_gainWr; ce && gainWrEn |=> pgaGain == $past(gainWrData); endproperty
    property p_ceil;
        ce && loopActive && !gainWrEn && pgaGain > ceilIdx |=> pgaGain == $past(ceilIdx);
    endproperty
    property p_floor;
        ce && loopActive && !gainWrEn && pgaGain < floorIdx |=> pgaGain == $past(floorIdx);
    endproperty
    property p_step;
        ce && loopActive && !gainWrEn && pgaGain <= ceilIdx && pgaGain >= floorIdx |=>
            pgaGain == $past(pgaGain) || pgaGain == $past(pgaGain) + 6'h01
            || pgaGain == $past(pgaGain) - 6'h01;
    endproperty
    property p_unmapped;
        ce && (regAddr < 7'h20 || regAddr > 7'h23) |=> regRdData == 9'h000;
    endproperty
    property p_gateRead; ce && regAddr == 7'h23 |=> regRdData[8:4] == 5'h00; endproperty
    property p_readBack;
        s_ctrlWrite ##1 s_readAfter |=> regRdData == $past(regWrData, 2);
    endproperty

    a_enable: assert property (p_enable) else $error("loop did not start");
    a_disable: assert property (p_disable) else $error("loop did not stop");
    a_offHold: assert property (p_offHold) else $error("gain moved while off");
    a_gainWr: assert property (p_gainWr) else $error("gain write lost");
    a_ceil: assert property (p_ceil) else $error("gain above ceiling");
    a_floor: assert property (p_floor) else $error("gain below floor");
    a_step: assert property (p_step) else $error("gain step too large");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_gateRead: assert property (p_gateRead) else $error("gate spare bits set");
    a_readBack: assert property (p_readBack) else $error("register readback");
endmodule : ilcl_level_loop_checker

bind ilcl_level_loop ilcl_level_loop_checker #(.SAMPLE_W(SAMPLE_W)) u_chk (
    .clk(clk), .arst_n(arst_n), .ce(ce), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .sampleStrobe(sampleStrobe),
    .adcSample(adcSample), .sampleRateCode(sampleRateCode), .gainWrEn(gainWrEn),
    .gainWrData(gainWrData), .pgaGain(pgaGain), .loopActive(loopActive));
`default_nettype wire

// File: tb/ilcl_level_loop_bench.sv
// Self-checking bench of the input level control loop
`timescale 1ns/1ps
`default_nettype none
module ilcl_level_loop_bench;
    logic        clk = 1'b0;
    logic        arst_n, ce, regWrEn, sampleStrobe, gainWrEn, loopActive;
    logic [6:0]  regAddr;
    logic [8:0]  regWrData, regRdData;
    logic [15:0] adcSample;
    logic [2:0]  sampleRateCode;
    logic [5:0]  gainWrData, pgaGain;
    int          errCount = 0;
    int          samplesChecked = 0;

    always #2.5 clk = ~clk;

    ilcl_level_loop #(.FALL_NORM_BASE(2), .RISE_NORM_BASE(4), .FALL_LIM_BASE(1),
        .RISE_LIM_BASE(2), .HOLD_BASE(2)) dut (
        .clk(clk), .arst_n(arst_n), .ce(ce), .regWrEn(regWrEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .sampleStrobe(sampleStrobe),
        .adcSample(adcSample), .sampleRateCode(sampleRateCode), .gainWrEn(gainWrEn),
        .gainWrData(gainWrData), .pgaGain(pgaGain), .loopActive(loopActive));

    task chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task gain(input logic [5:0] exp);
        chk({3'h0, pgaGain}, {3'h0, exp}, "gain");
    endtask : gain
    task wr(input logic [6:0] a, input logic [8:0] d);
        @(negedge clk) regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk) regWrEn = 1'b0;
    endtask : wr
    task rd(input logic [6:0] a, input logic [8:0] exp);
        @(negedge clk) regAddr = a;
        @(negedge clk) chk(regRdData, exp, "register");
    endtask : rd
    task gw(input logic [5:0] g);
        @(negedge clk) gainWrData = g;
        gainWrEn = 1'b1;
        @(negedge clk) gainWrEn = 1'b0;
    endtask : gw
    task smp(input logic [15:0] v, input int n);
        repeat (n) begin
            @(negedge clk) adcSample = v;
            sampleStrobe = 1'b1;
            @(negedge clk) sampleStrobe = 1'b0;
        end
        repeat (3) @(negedge clk);
    endtask : smp
    task restart(input logic [8:0] c);
        wr(ilcl_pkg::ADDR_CTRL_ONE, c & 9'h0ff);
        repeat (3) @(negedge clk);
        wr(ilcl_pkg::ADDR_CTRL_ONE, c);
        repeat (4) @(negedge clk);
    endtask : restart
    task tend(input string n);
        $display("test %s done", n);
    endtask : tend
    task completeRun;
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : completeRun

    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        $display("wrong value at %0t: watchdog expired", $time);
        completeRun();
    end

    initial begin
        {arst_n, regWrEn, sampleStrobe, gainWrEn} = 4'h0;
        ce = 1'b1;
        regAddr = 7'h20;
        regWrData = 9'h000;
        adcSample = 16'h0000;
        sampleRateCode = 3'h0;
        gainWrData = 6'h00;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        gain(ilcl_pkg::GAIN_RESET);
        chk({8'h00, loopActive}, 9'h000, "active");
        rd(7'h20, ilcl_pkg::CTRL_ONE_RESET);
        rd(7'h21, ilcl_pkg::CTRL_TWO_RESET);
        rd(7'h22, ilcl_pkg::CTRL_THREE_RESET);
        rd(7'h23, 9'h000);
        wr(7'h23, 9'h1ff);
        rd(7'h23, 9'h00f);
        wr(7'h30, 9'h1ff);
        rd(7'h30, 9'h000);
        wr(7'h23, 9'h000);
        tend("registers");
        wr(7'h22, 9'h000);
        wr(7'h20, 9'h000);
        smp(16'h3000, 4);
        gain(6'h10);
        restart(9'h110);
        smp(16'h0010, 5);
        gain(6'h12);
        smp(16'h0010, 40);
        gain(6'h17);
        tend("rise");
        restart(9'h110);
        smp(16'hd000, 5);
        gain(6'h14);
        wr(7'h20, 9'h108);
        smp(16'h0000, 0);
        gain(6'h0f);
        wr(7'h20, 9'h112);
        smp(16'h0000, 0);
        gain(6'h10);
        tend("limits");
        wr(7'h22, 9'h00a);
        restart(9'h110);
        smp(16'h3000, 5);
        gain(6'h0f);
        restart(9'h110);
        smp(16'h7800, 5);
        gain(6'h0c);
        tend("clamp");
        wr(7'h22, 9'h000);
        wr(7'h21, 9'h0ab);
        restart(9'h110);
        smp(16'h3000, 1);
        smp(16'h0010, 8);
        gain(6'h0b);
        wr(7'h21, 9'h00b);
        wr(7'h23, 9'h008);
        restart(9'h110);
        smp(16'h0001, 9);
        gain(6'h0b);
        wr(7'h23, 9'h000);
        restart(9'h110);
        smp(16'h0001, 5);
        gain(6'h0d);
        sampleRateCode = 3'h2;
        restart(9'h110);
        smp(16'h0001, 5);
        gain(6'h10);
        sampleRateCode = 3'h0;
        tend("hold gate rate");
        wr(7'h20, 9'h010);
        gw(6'h14);
        wr(7'h22, 9'h100);
        wr(7'h23, 9'h008);
        restart(9'h110);
        smp(16'hd000, 3);
        gain(6'h11);
        smp(16'h0001, 12);
        gain(6'h14);
        tend("limiter");
        wr(7'h20, 9'h010);
        smp(16'h3000, 4);
        gain(6'h14);
        gw(6'h2a);
        smp(16'h3000, 2);
        gain(6'h2a);
        tend("off");
        wr(7'h23, 9'h000);
        wr(7'h22, 9'h000);
        wr(7'h21, 9'h10b);
        restart(9'h138);
        smp(16'h0010, 1);
        gain(6'h2a);
        smp(16'hfff0, 1);
        gain(6'h2b);
        tend("zero cross");
        completeRun();
    end
endmodule : ilcl_level_loop_bench
`default_nettype wire
